// *** src/ddc_nco_frequency_translation.sv ***
`timescale 1ns/10ps
`include "ddc_regs.svh"

module ddc_nco_frequency_translation (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Converter samples, one per clock
    input wire logic [13:0] adc_i,
    input wire logic [13:0] adc_q,
    // Synchronisation and shadow set pins
    input wire logic sysref,
    input wire logic [3:0] gpio_sel,
    // Decimated output stream
    output logic [15:0] out_i,
    output logic [15:0] out_q,
    output logic out_valid
);

    // ==========================================================
    // Register file
    logic [5:0] ctrl_q;
    logic [3:0] index_q;
    logic [3:0] sel_q;
    logic [31:0] tune_lo_q;
    logic [31:0] offset_lo_q;
    logic [31:0] num_lo_q;
    logic [31:0] den_lo_q;
    logic [47:0] tune_bank [`SHADOW_SETS];
    logic [47:0] offset_bank [`SHADOW_SETS];
    logic [47:0] modulus_numerator_word_q;
    logic [47:0] modulus_denominator_word_q;
    logic [47:0] phase_accumulator_word_q;
    logic [47:0] mod_acc_q;

    wire logic wr_ctrl = reg_wr && reg_addr == `REG_CTRL;
    wire logic wr_index = reg_wr && reg_addr == `REG_INDEX;
    wire logic wr_tune_lo = reg_wr && reg_addr == `REG_TUNE_LO;
    wire logic wr_tune_hi = reg_wr && reg_addr == `REG_TUNE_HI;
    wire logic wr_offset_lo = reg_wr && reg_addr == `REG_OFFSET_LO;
    wire logic wr_offset_hi = reg_wr && reg_addr == `REG_OFFSET_HI;
    wire logic wr_num_lo = reg_wr && reg_addr == `REG_NUM_LO;
    wire logic wr_num_hi = reg_wr && reg_addr == `REG_NUM_HI;
    wire logic wr_den_lo = reg_wr && reg_addr == `REG_DEN_LO;
    wire logic wr_den_hi = reg_wr && reg_addr == `REG_DEN_HI;
    wire logic wr_sel = reg_wr && reg_addr == `REG_SEL;
    wire logic wr_soft = reg_wr && reg_addr == `REG_SOFT_RESET;

    wire ddc_pkg::if_mode_t mode =
        ddc_pkg::if_mode_t'(ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    wire logic c2r = ctrl_q[`CTRL_C2R];
    wire logic gain6 = ctrl_q[`CTRL_GAIN];
    wire logic cplx = ctrl_q[`CTRL_CPLX];

    // One resync source for accumulators and sequence counters
    wire logic sync = sysref || (wr_soft && reg_wdata[0]);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= `CTRL_RESET;
            index_q <= 4'h0;
            sel_q <= 4'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[5:0];
            if (wr_index) index_q <= reg_wdata[3:0];
            if (wr_sel) sel_q <= reg_wdata[3:0];
        end
    end

    // Low halves are staged so a 48-bit word lands in one cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tune_lo_q <= 32'h0000_0000;
            offset_lo_q <= 32'h0000_0000;
            num_lo_q <= 32'h0000_0000;
            den_lo_q <= 32'h0000_0000;
        end else begin
            if (wr_tune_lo) tune_lo_q <= reg_wdata;
            if (wr_offset_lo) offset_lo_q <= reg_wdata;
            if (wr_num_lo) num_lo_q <= reg_wdata;
            if (wr_den_lo) den_lo_q <= reg_wdata;
        end
    end

    // Shadow sets, written through the index register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int k = 0; k < `SHADOW_SETS; k++) begin
                tune_bank[k] <= `WORD_RESET;
                offset_bank[k] <= `WORD_RESET;
            end
        end else begin
            if (wr_tune_hi) tune_bank[index_q] <= {reg_wdata[15:0], tune_lo_q};
            if (wr_offset_hi) begin
                offset_bank[index_q] <= {reg_wdata[15:0], offset_lo_q};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            modulus_numerator_word_q <= `WORD_RESET;
            modulus_denominator_word_q <= `WORD_RESET;
        end else begin
            if (wr_num_hi) begin
                modulus_numerator_word_q <= {reg_wdata[15:0], num_lo_q};
            end
            if (wr_den_hi) begin
                modulus_denominator_word_q <= {reg_wdata[15:0], den_lo_q};
            end
        end
    end

    // ==========================================================
    // Oscillator
    wire logic [3:0] sel_src = ctrl_q[`CTRL_GPIO] ? gpio_sel : sel_q;
    wire logic [47:0] active_tune = tune_bank[sel_src];
    wire logic [47:0] active_offset = offset_bank[sel_src];

    wire logic mod_on = |modulus_numerator_word_q;
    wire logic [48:0] mod_sum = {1'b0, mod_acc_q}
        + {1'b0, modulus_numerator_word_q};
    wire logic [48:0] mod_less = mod_sum
        - {1'b0, modulus_denominator_word_q};
    wire logic mod_carry = mod_on
        && mod_sum >= {1'b0, modulus_denominator_word_q};
    // Signed word added modulo 2^48 gives the signed frequency
    wire logic [47:0] acc_step = active_tune + {47'h0, mod_carry};
    wire logic [47:0] acc_next = phase_accumulator_word_q + acc_step;

    // Writes to words never touch the accumulator
    always_ff @(posedge sys_clk) begin
        if (srst || sync) begin
            phase_accumulator_word_q <= `WORD_RESET;
            mod_acc_q <= `WORD_RESET;
        end else begin
            phase_accumulator_word_q <= acc_next;
            if (mod_on) begin
                mod_acc_q <= mod_carry ? mod_less[47:0] : mod_sum[47:0];
            end
        end
    end

    // Phase from shared accumulator, whatever set is active
    wire logic [47:0] phase_now = phase_accumulator_word_q + active_offset;

    function automatic logic signed [15:0] qsin(input logic [4:0] k);
        case (k)
            5'h00: qsin = 16'h0000;
            5'h01: qsin = 16'h0c8c;
            5'h02: qsin = 16'h18f9;
            5'h03: qsin = 16'h2528;
            5'h04: qsin = 16'h30fb;
            5'h05: qsin = 16'h3c56;
            5'h06: qsin = 16'h471c;
            5'h07: qsin = 16'h5133;
            5'h08: qsin = 16'h5a82;
            5'h09: qsin = 16'h62f1;
            5'h0a: qsin = 16'h6a6d;
            5'h0b: qsin = 16'h70e2;
            5'h0c: qsin = 16'h7641;
            5'h0d: qsin = 16'h7a7c;
            5'h0e: qsin = 16'h7d89;
            5'h0f: qsin = 16'h7f61;
            default: qsin = 16'h7fff;
        endcase
    endfunction

    // Quarter-wave table; only the top six phase bits address it
    function automatic logic signed [15:0] wave(input logic [5:0] p);
        logic [4:0] k;
        logic signed [15:0] m;
        k = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
        m = qsin(k);
        wave = p[5] ? -m : m;
    endfunction

    function automatic logic signed [15:0] sat(input logic signed [17:0] v);
        if (v > 18'sh07fff) sat = 16'sh7fff;
        else if (v < -18'sh08000) sat = 16'sh8000;
        else sat = v[15:0];
    endfunction

    function automatic logic signed [15:0] neg(input logic signed [15:0] v);
        neg = (v == 16'sh8000) ? 16'sh7fff : -v;
    endfunction

    wire logic signed [15:0] sin_v = wave(phase_now[47:42]);
    wire logic signed [15:0] cos_v = wave(phase_now[47:42] + 6'h10);

    // ==========================================================
    // Mixer
    wire logic test_on = mode == ddc_pkg::MODE_TEST;
    // 14-bit samples ride in the top of a 16-bit word
    wire logic signed [15:0] xi = test_on ? {`TEST_LEVEL, 2'b00}
        : {adc_i, 2'b00};
    wire logic signed [15:0] xq = (test_on || !cplx) ? 16'sh0000
        : {adc_q, 2'b00};

    // Multiply by exp(-j phase)
    wire logic signed [31:0] p_ic = xi * cos_v;
    wire logic signed [31:0] p_qs = xq * sin_v;
    wire logic signed [31:0] p_qc = xq * cos_v;
    wire logic signed [31:0] p_is = xi * sin_v;
    wire logic signed [32:0] var_i = 33'(p_ic) + 33'(p_qs);
    wire logic signed [32:0] var_q = 33'(p_qc) - 33'(p_is);

    logic [1:0] qcnt_q;
    logic signed [15:0] mix_i_q;
    logic signed [15:0] mix_q_q;
    logic mix_v_q;
    logic signed [15:0] mix_i_d;
    logic signed [15:0] mix_q_d;

    always_comb begin
        mix_i_d = xi;
        mix_q_d = xq;
        case (mode)
            ddc_pkg::MODE_VARIABLE, ddc_pkg::MODE_TEST: begin
                mix_i_d = sat(var_i[32:15]);
                mix_q_d = sat(var_q[32:15]);
            end
            ddc_pkg::MODE_QUARTER: begin
                // Swaps and negation only: the multiplier products are unused here
                case (qcnt_q)
                    2'h0: begin
                        mix_i_d = xi;
                        mix_q_d = xq;
                    end
                    2'h1: begin
                        mix_i_d = xq;
                        mix_q_d = neg(xi);
                    end
                    2'h2: begin
                        mix_i_d = neg(xi);
                        mix_q_d = neg(xq);
                    end
                    default: begin
                        mix_i_d = neg(xq);
                        mix_q_d = xi;
                    end
                endcase
            end
            default: begin
                // Oscillator output unused in this mode
                mix_i_d = xi;
                mix_q_d = xq;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst || sync) qcnt_q <= 2'h0;
        else qcnt_q <= qcnt_q + 2'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mix_i_q <= 16'h0000;
            mix_q_q <= 16'h0000;
            mix_v_q <= 1'b0;
        end else begin
            mix_i_q <= mix_i_d;
            mix_q_q <= mix_q_d;
            mix_v_q <= 1'b1;
        end
    end

    // ==========================================================
    // Decimation chain, four halfband stages
    sample_if st [5] ();

    assign st[0].valid = mix_v_q;
    assign st[0].i = mix_i_q;
    assign st[0].q = mix_q_q;

    for (genvar g = 0; g < 4; g++) begin : g_hb
        halfband_stage u_stage (
            .sys_clk(sys_clk),
            .srst(srst),
            .in_s(st[g]),
            .out_s(st[g+1])
        );
    end

    // ==========================================================
    // Gain and complex to real
    // Real output taps one stage earlier: half the decimation
    wire logic post_v = c2r ? st[3].valid : st[4].valid;
    wire logic signed [15:0] post_i = c2r ? st[3].i : st[4].i;
    wire logic signed [15:0] post_q = c2r ? st[3].q : st[4].q;
    wire logic signed [15:0] gi = gain6
        ? sat({post_i[15], post_i, 1'b0}) : post_i;
    wire logic signed [15:0] gq = gain6
        ? sat({post_q[15], post_q, 1'b0}) : post_q;

    logic [1:0] rcnt_q;
    logic signed [15:0] real_v;

    // Real part of the quarter-rate rotation
    always_comb begin
        case (rcnt_q)
            2'h0: real_v = gi;
            2'h1: real_v = neg(gq);
            2'h2: real_v = neg(gi);
            default: real_v = gq;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst || sync) rcnt_q <= 2'h0;
        else if (post_v && c2r) rcnt_q <= rcnt_q + 2'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_i <= 16'h0000;
            out_q <= 16'h0000;
            out_valid <= 1'b0;
        end else begin
            out_valid <= post_v;
            if (post_v) begin
                out_i <= c2r ? real_v : gi;
                out_q <= c2r ? 16'h0000 : gq;
            end
        end
    end

    // ==========================================================
    // Register read
    wire logic [31:0] rd_value =
        (reg_addr == `REG_CTRL) ? {26'h0, ctrl_q} :
        (reg_addr == `REG_INDEX) ? {28'h0, index_q} :
        (reg_addr == `REG_TUNE_LO) ? tune_bank[index_q][31:0] :
        (reg_addr == `REG_TUNE_HI) ? {16'h0, tune_bank[index_q][47:32]} :
        (reg_addr == `REG_OFFSET_LO) ? offset_bank[index_q][31:0] :
        (reg_addr == `REG_OFFSET_HI) ?
            {16'h0, offset_bank[index_q][47:32]} :
        (reg_addr == `REG_NUM_LO) ? modulus_numerator_word_q[31:0] :
        (reg_addr == `REG_NUM_HI) ?
            {16'h0, modulus_numerator_word_q[47:32]} :
        (reg_addr == `REG_DEN_LO) ? modulus_denominator_word_q[31:0] :
        (reg_addr == `REG_DEN_HI) ?
            {16'h0, modulus_denominator_word_q[47:32]} :
        (reg_addr == `REG_SEL) ? {28'h0, sel_q} :
        (reg_addr == `REG_STATUS) ? {27'h0, mod_on, sel_src} :
        (reg_addr == `REG_PHASE) ? phase_accumulator_word_q[47:16] :
        32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (srst) reg_rdata <= 32'h0000_0000;
        else reg_rdata <= reg_rd ? rd_value : 32'h0000_0000;
    end

    // ==========================================================
    // Checks
    // Pacing is only judged once the tap point has settled after a write
    logic [7:0] since_v_q;
    logic [7:0] since_ctrl_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            since_v_q <= 8'hff;
            since_ctrl_q <= 8'h00;
        end else begin
            if (out_valid) since_v_q <= 8'h01;
            else if (since_v_q != 8'hff) since_v_q <= since_v_q + 8'h01;
            if (wr_ctrl) since_ctrl_q <= 8'h00;
            else if (since_ctrl_q != 8'hff) begin
                since_ctrl_q <= since_ctrl_q + 8'h01;
            end
        end
    end

    acc_sync_a: assert property (@(posedge sys_clk) disable iff (srst)
        sync |=> phase_accumulator_word_q == 48'h0 ##1
            phase_accumulator_word_q == $past(acc_step))
        else $error("accumulator not restarted by sync");

    acc_step_a: assert property (@(posedge sys_clk) disable iff (srst)
        !sync |=> phase_accumulator_word_q - $past(phase_accumulator_word_q)
            == $past(active_tune) + {47'h0, $past(mod_carry)})
        else $error("accumulator step wrong");

    mod_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        !mod_on && !sync |=> mod_acc_q == $past(mod_acc_q))
        else $error("modulus logic active with zero numerator");

    zero_if_a: assert property (@(posedge sys_clk) disable iff (srst)
        mode == ddc_pkg::MODE_ZERO_IF && !cplx
            |=> mix_i_q == $past(xi) && mix_q_q == 16'sh0000)
        else $error("zero IF did not bypass mixer");

    quarter_seq_a: assert property (@(posedge sys_clk) disable iff (srst)
        mode == ddc_pkg::MODE_QUARTER && qcnt_q == 2'h1 && !cplx
            |=> mix_i_q == 16'sh0000 && mix_q_q == neg($past(xi)))
        else $error("quarter rotation out of step");

    test_level_a: assert property (@(posedge sys_clk) disable iff (srst)
        test_on && phase_now[47:42] == 6'h00
            |=> mix_i_q == 16'sh7fdb && mix_q_q == 16'sh0000)
        else $error("test level not mixed");

    real_out_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(c2r) && out_valid |-> out_q == 16'h0000)
        else $error("Q carries data in real mode");

    decim_rate_a: assert property (@(posedge sys_clk) disable iff (srst)
        out_valid && since_ctrl_q >= 8'h20 |-> since_v_q >= 8'h08)
        else $error("output rate above one in eight");

endmodule

// *** src/ddc_regs.svh ***
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH

// ==========================================================
// Register offsets, byte addresses on the 8-bit port
`define REG_CTRL 8'h00
`define REG_INDEX 8'h04
`define REG_TUNE_LO 8'h08
`define REG_TUNE_HI 8'h0c
`define REG_OFFSET_LO 8'h10
`define REG_OFFSET_HI 8'h14
`define REG_NUM_LO 8'h18
`define REG_NUM_HI 8'h1c
`define REG_DEN_LO 8'h20
`define REG_DEN_HI 8'h24
`define REG_SEL 8'h28
`define REG_SOFT_RESET 8'h2c
`define REG_STATUS 8'h30
`define REG_PHASE 8'h34

// ==========================================================
// Control register fields
`define CTRL_MODE_HI 5
`define CTRL_MODE_LO 4
`define CTRL_C2R 3
`define CTRL_GAIN 2
`define CTRL_CPLX 1
`define CTRL_GPIO 0
`define CTRL_RESET 6'h00

// ==========================================================
// Fixed values
`define WORD_RESET 48'h0000_0000_0000
`define TEST_LEVEL 14'h1ff7
`define SHADOW_SETS 16

`endif

// *** src/ddc_pkg.sv ***
package ddc_pkg;

    typedef enum logic [1:0] {
        MODE_VARIABLE = 2'h0,
        MODE_ZERO_IF = 2'h1,
        MODE_QUARTER = 2'h2,
        MODE_TEST = 2'h3
    } if_mode_t;

endpackage

// *** src/sample_if.sv ***
`timescale 1ns/10ps

interface sample_if;
    logic valid;
    logic signed [15:0] i;
    logic signed [15:0] q;

    modport source (output valid, output i, output q);
    modport sink (input valid, input i, input q);
endinterface

// *** src/halfband_stage.sv ***
`timescale 1ns/10ps

module halfband_stage (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Streams
    sample_if.sink in_s,
    sample_if.source out_s
);

    logic signed [15:0] i1_q;
    logic signed [15:0] i2_q;
    logic signed [15:0] q1_q;
    logic signed [15:0] q2_q;
    logic odd_q;
    logic valid_q;
    logic signed [15:0] oi_q;
    logic signed [15:0] oq_q;

    // Taps 1-2-1 over 4: unity dc gain, so no overflow
    wire logic [17:0] sum_i = {{2{i2_q[15]}}, i2_q}
        + {i1_q[15], i1_q, 1'b0} + {{2{in_s.i[15]}}, in_s.i};
    wire logic [17:0] sum_q = {{2{q2_q[15]}}, q2_q}
        + {q1_q[15], q1_q, 1'b0} + {{2{in_s.q[15]}}, in_s.q};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            i1_q <= 16'h0000;
            i2_q <= 16'h0000;
            q1_q <= 16'h0000;
            q2_q <= 16'h0000;
            odd_q <= 1'b0;
        end else if (in_s.valid) begin
            i1_q <= in_s.i;
            i2_q <= i1_q;
            q1_q <= in_s.q;
            q2_q <= q1_q;
            odd_q <= ~odd_q;
        end
    end

    // Keep every second filtered sample
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            valid_q <= 1'b0;
            oi_q <= 16'h0000;
            oq_q <= 16'h0000;
        end else begin
            valid_q <= in_s.valid && odd_q;
            if (in_s.valid && odd_q) begin
                oi_q <= sum_i[17:2];
                oq_q <= sum_q[17:2];
            end
        end
    end

    assign out_s.valid = valid_q;
    assign out_s.i = oi_q;
    assign out_s.q = oq_q;

endmodule

// *** verif/ddc_far_side.sv ***
`timescale 1ns/10ps

// ==========================================================
// Converter samples in, decimated stream out
module ddc_far_side (
    // Clock
    input wire logic sys_clk,
    // Sample level to send
    input wire logic [13:0] level,
    // Converter side
    output logic [13:0] adc_i,
    output logic [13:0] adc_q,
    // Output stream watch
    input wire logic out_valid,
    output logic [7:0] gap_q
);
    logic [7:0] cnt_q;

    initial begin
        adc_i = 14'h0000;
        adc_q = 14'h0000;
        gap_q = 8'h00;
        cnt_q = 8'h00;
    end

    // One sample every clock, no gaps
    always @(posedge sys_clk) begin
        adc_i <= level;
        // Q toggles so an ignored input never looks like a stable zero
        adc_q <= ~adc_q;
    end

    // Spacing between output pulses
    always @(posedge sys_clk) begin
        if (out_valid) begin
            gap_q <= cnt_q;
            cnt_q <= 8'h01;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// *** verif/ddc_nco_frequency_translation_bench.sv ***
`timescale 1ns/10ps
`include "ddc_regs.svh"

module ddc_nco_frequency_translation_bench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [13:0] adc_i, adc_q, level = 14'h0000;
    logic sysref = 1'b0;
    logic [3:0] gpio_sel = 4'h0;
    logic [15:0] out_i, out_q;
    logic out_valid;
    logic [7:0] gap;
    logic [31:0] v, p1;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [5:0] ctrl_tab [3] = '{6'h18, 6'h30, 6'h20};
    logic [7:0] gap_tab [3] = '{8'h08, 8'h10, 8'h10};

    always #2.5 sys_clk = ~sys_clk;

    ddc_nco_frequency_translation u_dut (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_i(adc_i),
        .adc_q(adc_q), .sysref(sysref), .gpio_sel(gpio_sel),
        .out_i(out_i), .out_q(out_q), .out_valid(out_valid));

    ddc_far_side u_far (.sys_clk(sys_clk), .level(level), .adc_i(adc_i),
        .adc_q(adc_q), .out_valid(out_valid), .gap_q(gap));

    // ==========================================================
    // Bus tasks and compare
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Two reads one cycle apart: difference is one accumulator step
    task automatic phase_step(output logic [31:0] d);
        logic [31:0] a;
        @(posedge sys_clk);
        reg_addr <= `REG_PHASE;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        #1 a = reg_rdata;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata - a;
    endtask

    task automatic wr48(input logic [7:0] a, input logic [47:0] w);
        wr(a, w[31:0]);
        wr(a + 8'h04, {16'h0000, w[47:32]});
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 1300 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // ==========================================================
    // Sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(`REG_CTRL, v); check("ctrl", v, 32'h0);
        rd(`REG_STATUS, v); check("status", v, 32'h0);
        rd(`REG_PHASE, v); check("phase", v, 32'h0);
        wr(`REG_INDEX, 32'h1);
        wr(`REG_TUNE_LO, 32'h0);
        wr(`REG_TUNE_HI, 32'hffff_0001);
        rd(`REG_TUNE_HI, v); check("tune hi", v, 32'h1);
        wr(`REG_TUNE_LO, 32'h1234_0000);
        rd(`REG_TUNE_LO, v); check("tune lo", v, 32'h0);
        wr(`REG_INDEX, 32'h0);
        wr48(`REG_TUNE_LO, 48'h0000_0001_0000);
        rd(`REG_TUNE_HI, v); check("bank0", v, 32'h0);
        phase_step(v); check("step0", v, 32'h1);
        wr(`REG_SEL, 32'h1);
        rd(`REG_STATUS, v); check("sel", v, 32'h1);
        phase_step(v); check("step1", v, 32'h0001_0000);
        wr(`REG_CTRL, 32'h1);
        rd(`REG_STATUS, v); check("gpio", v, 32'h0);
        wr48(`REG_NUM_LO, 48'h5);
        rd(`REG_STATUS, v); check("modulus", v, 32'h10);
        wr48(`REG_NUM_LO, 48'h0);
        rd(`REG_STATUS, v); check("no mod", v, 32'h0);
        wr48(`REG_TUNE_LO, 48'h0);
        rd(`REG_PHASE, p1);
        wr48(`REG_OFFSET_LO, 48'h1234_5678_9abc);
        rd(`REG_PHASE, v); check("offset", v, p1);
        wr(`REG_SOFT_RESET, 32'h1);
        repeat (3) @(posedge sys_clk);
        rd(`REG_PHASE, v); check("soft", v, 32'h0);
        gpio_sel <= 4'h1;
        repeat (20) @(posedge sys_clk);
        gpio_sel <= 4'h0;
        sysref <= 1'b1;
        @(posedge sys_clk);
        sysref <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(`REG_PHASE, v); check("sysref", v, 32'h0);
        // Still phase so the test-level check sees a known mixer phase
        wr(`REG_SEL, 32'h0);
        wr48(`REG_OFFSET_LO, 48'h0);
        level <= 14'h0100;
        wr(`REG_CTRL, 32'h10);
        repeat (200) @(posedge sys_clk);
        check("zif i", {16'h0, out_i}, 32'h0400);
        check("zif q", {16'h0, out_q}, 32'h0);
        check("cplx gap", {24'h0, gap}, 32'h10);
        wr(`REG_CTRL, 32'h14);
        repeat (200) @(posedge sys_clk);
        check("gain", {16'h0, out_i}, 32'h0800);
        for (int k = 0; k < 3; k++) begin
            wr(`REG_CTRL, {26'h0, ctrl_tab[k]});
            repeat (200) @(posedge sys_clk);
            check("gap", {24'h0, gap}, {24'h0, gap_tab[k]});
        end
        wr(`REG_CTRL, 32'h18);
        repeat (200) @(posedge sys_clk);
        check("real q", {16'h0, out_q}, 32'h0);
        stop_test();
    end
endmodule
